// ---- hw/dmcc_channel.sv ----
// DMA channel control engine with AXI4-Lite registers and outbound write FIFO
// Notes on behaviour
// - Dummy mode adds write to source location
// - Reload restores pointers and count next start
// - Soft request starts transfer, clears when done
// - Transfers per request follow transfer mode
// - Pointer modes: hold, increment, decrement, indirect
// - Mode field: one-shot, continuous, repeated variants
// - Channel enable bit gates transfer start and trigger capture
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module dmcc_fifo #(
    parameter int W = 33,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [W-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [W-1:0] m_data,
    output logic [$clog2(D):0] level
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q;
    wire push = s_valid && s_ready;
    wire pop = m_valid && m_ready;

    assign s_ready = (cnt_q != D[PW:0]);
    assign m_valid = (cnt_q != '0);
    assign m_data = mem[rp_q];
    assign level = cnt_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= s_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module dmcc_channel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dmcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dmcc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dmcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dmcc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic periph_trig,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [dmcc_pkg::REG_W-1:0] rd_addr,
    output logic rd_byte,
    input wire logic rd_rsp_valid,
    input wire logic [dmcc_pkg::REG_W-1:0] rd_rsp_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [dmcc_pkg::REG_W-1:0] wr_addr,
    output logic [dmcc_pkg::REG_W-1:0] wr_data,
    output logic wr_byte
);
    import dmcc_pkg::*;

    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
            input logic [REG_W-1:0] wd, input logic [1:0] strb);
        merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic [REG_W-1:0] step_ptr(input logic [REG_W-1:0] p,
            input logic [1:0] mode, input logic byte_sz);
        logic [REG_W-1:0] inc;
        inc = byte_sz ? 16'h0001 : 16'h0002;
        case (mode)
            STEP_INC: step_ptr = p + inc;
            STEP_DEC: step_ptr = p - inc;
            default: step_ptr = p;
        endcase
    endfunction

    dmcc_state_t state_q, state_d;
    logic [CTRL_W-1:0] ctrl_q;
    logic [REG_W-1:0] src_q, dst_q, cnt_q, src_sav_q, dst_sav_q, cnt_sav_q;
    logic [REG_W-1:0] eff_src_q, eff_dst_q, data_q;
    logic rld_pend_q, trig_pend_q, done_q, rd_wait_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_full_q, w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [REG_W-1:0] w_data_q;
    logic [1:0] w_strb_q, bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic rd_valid_q, rd_byte_q, wr_valid_q, wr_byte_q;
    logic [REG_W-1:0] rd_addr_q, wr_addr_q, wr_data_q;
    logic fifo_s_ready, fifo_m_valid;
    logic [FIFO_W-1:0] fifo_m_data;
    logic [LVL_W-1:0] fifo_lvl;

    // Control field decode
    wire ch_on = ctrl_q[CB_ON];
    wire sz_byte = ctrl_q[CB_SIZE];
    wire [1:0] trm = ctrl_q[CB_TRM +: 2];
    wire [1:0] dmode = ctrl_q[CB_DST +: 2];
    wire [1:0] smode = ctrl_q[CB_SRC +: 2];
    wire continuous = trm[1];
    wire repeated = trm[0];

    // Register write decode
    wire wr_exec = aw_full_q && w_full_q && !bvalid_q;
    wire ws_ctrl = wr_exec && (aw_addr_q == OFF_CTRL);
    wire ws_src = wr_exec && (aw_addr_q == OFF_SRC);
    wire ws_dst = wr_exec && (aw_addr_q == OFF_DST);
    wire ws_cnt = wr_exec && (aw_addr_q == OFF_CNT);
    wire ws_stat = wr_exec && (aw_addr_q == OFF_STAT);
    wire wr_hit = ws_ctrl || ws_src || ws_dst || ws_cnt || ws_stat;
    wire [REG_W-1:0] ctrl_wr = merge16({5'h00, ctrl_q}, w_data_q, w_strb_q);
    wire [REG_W-1:0] src_wr = merge16(src_q, w_data_q, w_strb_q);
    wire [REG_W-1:0] dst_wr = merge16(dst_q, w_data_q, w_strb_q);
    wire [REG_W-1:0] cnt_wr = merge16(cnt_q, w_data_q, w_strb_q);

    // Engine events
    wire pending = ctrl_q[CB_SOFT] || trig_pend_q;
    wire start = (state_q == ST_IDLE) && ch_on && pending
        && ((cnt_q != '0) || rld_pend_q);
    wire restore = start && rld_pend_q;
    wire elem_done = (state_q == ST_NEXT);
    wire last = (cnt_q == 16'h0001);
    wire blk_end = elem_done && last;
    wire soft_clr = elem_done && (!continuous || last);
    wire on_clr = blk_end && !repeated;
    wire [REG_W-1:0] cur_src = restore ? src_sav_q : src_q;
    wire [REG_W-1:0] cur_dst = restore ? dst_sav_q : dst_q;
    wire [REG_W-1:0] src_nx = step_ptr(src_q, smode, sz_byte);
    wire [REG_W-1:0] dst_nx = step_ptr(dst_q, dmode, sz_byte);
    wire rsp_ok = rd_wait_q && rd_rsp_valid;

    // Next control value; software write in the same cycle beats hardware clear
    wire [CTRL_W-1:0] ctrl_base = ws_ctrl ? ctrl_wr[CTRL_W-1:0] : ctrl_q;
    wire soft_d = ws_ctrl ? ctrl_wr[CB_SOFT] : (ctrl_q[CB_SOFT] && !soft_clr);
    wire on_d = ws_ctrl ? ctrl_wr[CB_ON] : (ch_on && !on_clr);
    wire [CTRL_W-1:0] ctrl_d = {ctrl_base[CB_DUMMY:CB_RELOAD], soft_d,
        ctrl_base[CB_SRC+1:CB_SIZE], on_d};

    wire [REG_W-1:0] src_d = ws_src ? src_wr : (restore ? src_sav_q
        : (elem_done ? src_nx : src_q));
    wire [REG_W-1:0] dst_d = ws_dst ? dst_wr : (restore ? dst_sav_q
        : (elem_done ? dst_nx : dst_q));
    wire [REG_W-1:0] cnt_d = ws_cnt ? cnt_wr : (restore ? cnt_sav_q
        : (elem_done ? cnt_q - 16'h0001 : cnt_q));
    wire rld_d = blk_end ? (ctrl_q[CB_RELOAD] || repeated) : (rld_pend_q && !restore);
    wire done_d = blk_end || (done_q && !(ws_stat && w_strb_q[0] && w_data_q[SB_DONE]));

    // Memory read and FIFO push selection
    wire rd_issue = ((state_q == ST_SIND) || (state_q == ST_RD) || (state_q == ST_DIND))
        && !rd_valid_q && !rd_wait_q;
    wire [REG_W-1:0] rd_addr_d = (state_q == ST_SIND) ? src_q
        : ((state_q == ST_DIND) ? dst_q : eff_src_q);
    wire fifo_s_valid = (state_q == ST_PUSH) || (state_q == ST_NULL);
    wire push_ok = fifo_s_valid && fifo_s_ready;
    wire [FIFO_W-1:0] fifo_s_data = (state_q == ST_NULL)
        ? {eff_src_q, data_q, sz_byte} : {eff_dst_q, data_q, sz_byte};
    wire fifo_m_ready = !wr_valid_q || wr_ready;
    wire [ADDR_W-1:0] ar_take_addr = s_axi_araddr;
    wire [REG_W-1:0] stat_rd = {2'b00, fifo_lvl, 5'h00, done_q, rld_pend_q,
        (state_q != ST_IDLE)};
    wire [REG_W-1:0] reg_rd = (ar_take_addr == OFF_CTRL) ? {5'h00, ctrl_q}
        : (ar_take_addr == OFF_SRC) ? src_q : (ar_take_addr == OFF_DST) ? dst_q
        : (ar_take_addr == OFF_CNT) ? cnt_q : stat_rd;
    wire rd_hit = (ar_take_addr == OFF_CTRL) || (ar_take_addr == OFF_SRC)
        || (ar_take_addr == OFF_DST) || (ar_take_addr == OFF_CNT)
        || (ar_take_addr == OFF_STAT);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start) state_d = (smode == STEP_IND) ? ST_SIND : ST_RD;
            ST_SIND: if (rsp_ok) state_d = ST_RD;
            ST_RD: if (rsp_ok) state_d = (dmode == STEP_IND) ? ST_DIND : ST_PUSH;
            ST_DIND: if (rsp_ok) state_d = ST_PUSH;
            ST_PUSH: if (push_ok) state_d = ctrl_q[CB_DUMMY] ? ST_NULL : ST_NEXT;
            ST_NULL: if (push_ok) state_d = ST_NEXT;
            ST_NEXT: begin
                if (continuous && !last) begin
                    state_d = (smode == STEP_IND) ? ST_SIND : ST_RD;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    dmcc_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .clk(aclk),
        .rst_n(aresetn),
        .s_valid(fifo_s_valid),
        .s_ready(fifo_s_ready),
        .s_data(fifo_s_data),
        .m_valid(fifo_m_valid),
        .m_ready(fifo_m_ready),
        .m_data(fifo_m_data),
        .level(fifo_lvl)
    );

    // Channel registers and engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            ctrl_q <= CTRL_RST;
            src_q <= PTR_RST;
            dst_q <= PTR_RST;
            cnt_q <= PTR_RST;
            rld_pend_q <= 1'b0;
            trig_pend_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            src_q <= src_d;
            dst_q <= dst_d;
            cnt_q <= cnt_d;
            rld_pend_q <= rld_d;
            trig_pend_q <= (periph_trig && ch_on) || (trig_pend_q && !start);
            done_q <= done_d;
        end
    end

    // Saved values for reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sav_q <= PTR_RST;
            dst_sav_q <= PTR_RST;
            cnt_sav_q <= PTR_RST;
        end else begin
            src_sav_q <= ws_src ? src_wr : src_sav_q;
            dst_sav_q <= ws_dst ? dst_wr : dst_sav_q;
            cnt_sav_q <= ws_cnt ? cnt_wr : cnt_sav_q;
        end
    end

    // Effective addresses and data of the element in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_src_q <= PTR_RST;
            eff_dst_q <= PTR_RST;
            data_q <= PTR_RST;
        end else begin
            if (start || elem_done) begin
                eff_src_q <= start ? cur_src : src_nx;
                eff_dst_q <= start ? cur_dst : dst_nx;
            end else if (rsp_ok && (state_q == ST_SIND)) begin
                eff_src_q <= rd_rsp_data;
            end else if (rsp_ok && (state_q == ST_DIND)) begin
                eff_dst_q <= rd_rsp_data;
            end
            if (rsp_ok && (state_q == ST_RD)) begin
                data_q <= rd_rsp_data;
            end
        end
    end

    // Read request port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_valid_q <= 1'b0;
            rd_wait_q <= 1'b0;
            rd_addr_q <= PTR_RST;
            rd_byte_q <= 1'b0;
        end else begin
            if (rd_issue) begin
                rd_valid_q <= 1'b1;
                rd_addr_q <= rd_addr_d;
                rd_byte_q <= (state_q == ST_RD) && sz_byte;
            end else if (rd_valid_q && rd_ready) begin
                rd_valid_q <= 1'b0;
                rd_wait_q <= 1'b1;
            end else if (rsp_ok) begin
                rd_wait_q <= 1'b0;
            end
        end
    end

    // Write output stage after the FIFO
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_valid_q <= 1'b0;
            wr_addr_q <= PTR_RST;
            wr_data_q <= PTR_RST;
            wr_byte_q <= 1'b0;
        end else if (fifo_m_ready) begin
            wr_valid_q <= fifo_m_valid;
            {wr_addr_q, wr_data_q, wr_byte_q} <= fifo_m_data;
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata[REG_W-1:0];
                w_strb_q <= s_axi_wstrb[1:0];
            end
            if (wr_exec) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? {16'h0000, reg_rd} : 32'h0000_0000;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rd_valid = rd_valid_q;
    assign rd_addr = rd_addr_q;
    assign rd_byte = rd_byte_q;
    assign wr_valid = wr_valid_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign wr_byte = wr_byte_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_NULL_WRITE: assert property (
        (state_q == ST_PUSH) && push_ok |=> (state_q == ST_NULL) == $past(ctrl_q[CB_DUMMY]))
        else $error("Dummy source write not matched to mode bit");
    AST_NULL_ADDR: assert property (
        (state_q == ST_NULL) |-> fifo_s_data[FIFO_W-1 -: REG_W] == eff_src_q)
        else $error("Dummy write not aimed at source location");
    AST_RELOAD: assert property (
        restore |=> (src_q == $past(src_sav_q)) && (cnt_q == $past(cnt_sav_q)))
        else $error("Reload did not restore saved values");
    AST_SOFT_CLEAR: assert property (
        soft_clr && !ws_ctrl |=> !ctrl_q[CB_SOFT])
        else $error("Soft request not cleared after transfer");
    AST_ONE_SHOT: assert property (
        elem_done && !continuous |=> (state_q == ST_IDLE) ##1 (state_q == ST_IDLE) [*1])
        else $error("One-shot mode moved more than one element");
    AST_STEP_INC: assert property (
        elem_done && (smode == STEP_INC) && !sz_byte && !ws_src
        |=> src_q == $past(src_q) + 16'h0002)
        else $error("Word increment of source pointer wrong");
    AST_CONTINUE: assert property (
        elem_done && continuous && !last |=> (state_q != ST_IDLE) [*2])
        else $error("Continuous mode stopped before count ran out");
    AST_DISABLED: assert property (
        (state_q == ST_IDLE) && !ch_on |=> (state_q == ST_IDLE))
        else $error("Disabled channel started a transfer");

    COV_ONE_SHOT: cover property (blk_end && !continuous && !repeated);
    COV_CONT_REPEAT: cover property (blk_end && continuous && repeated);
    COV_NULL: cover property ((state_q == ST_NULL) && push_ok);
    COV_FIFO_FULL: cover property (!fifo_s_ready);
endmodule

// ---- shared/dmcc_pkg.sv ----
// Constants and types shared by the DMA channel control block
package dmcc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CTRL_W = 11;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SRC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DST = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CNT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
    // Control register field positions
    localparam int CB_ON = 0;
    localparam int CB_SIZE = 1;
    localparam int CB_TRM = 2;
    localparam int CB_DST = 4;
    localparam int CB_SRC = 6;
    localparam int CB_SOFT = 8;
    localparam int CB_RELOAD = 9;
    localparam int CB_DUMMY = 10;
    // Status register field positions
    localparam int SB_BUSY = 0;
    localparam int SB_RLD = 1;
    localparam int SB_DONE = 2;
    localparam int SB_LVL = 8;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam logic [REG_W-1:0] PTR_RST = 16'h0000;
    // Pointer step codes
    localparam logic [1:0] STEP_HOLD = 2'b00;
    localparam logic [1:0] STEP_INC = 2'b01;
    localparam logic [1:0] STEP_DEC = 2'b10;
    localparam logic [1:0] STEP_IND = 2'b11;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Outbound write FIFO: address, data, byte flag
    localparam int FIFO_W = 2 * REG_W + 1;
    localparam int FIFO_D = 32;
    localparam int LVL_W = 6;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SIND, ST_RD, ST_DIND, ST_PUSH, ST_NULL, ST_NEXT
    } dmcc_state_t;
endpackage

// ---- test/dmcc_mem_model.sv ----
// Memory and peripheral model on the far side of the channel
`timescale 1ns/1ps
module dmcc_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [15:0] rd_addr,
    output logic rd_rsp_valid,
    output logic [15:0] rd_rsp_data,
    output logic wr_ready
);
    logic pend_q;
    logic [1:0] dly_q;
    logic [15:0] adr_q;
    // Random stalls; response data scrambled between pulses
    always @(posedge aclk) begin
        rd_rsp_valid <= 1'b0;
        rd_rsp_data <= ~rd_rsp_data;
        wr_ready <= !stall && ($urandom_range(3) != 0);
        if (!aresetn) begin
            rd_ready <= 1'b0;
            pend_q <= 1'b0;
            rd_rsp_data <= 16'h0000;
        end else if (pend_q) begin
            dly_q <= dly_q - 2'd1;
            if (dly_q == 2'd0) begin
                rd_rsp_valid <= 1'b1;
                rd_rsp_data <= adr_q ^ 16'h5a3c;
                pend_q <= 1'b0;
            end
        end else if (rd_valid && rd_ready) begin
            pend_q <= 1'b1;
            adr_q <= rd_addr;
            dly_q <= 2'($urandom_range(2));
            rd_ready <= 1'b0;
        end else begin
            rd_ready <= rd_valid && ($urandom_range(1) != 0);
        end
    end
endmodule

// ---- test/dmcc_channel_tb.sv ----
// Self-checking testbench for the DMA channel control block
`timescale 1ns/1ps
module dmcc_channel_tb;
    import dmcc_pkg::*;
    typedef struct packed {logic [15:0] a; logic [15:0] d; logic [15:0] m; logic b;} dmcc_wexp_t;
    typedef struct packed {logic [31:0] m; logic [1:0] r; logic [31:0] d;} dmcc_rexp_t;
    logic aclk = 0, aresetn = 0, periph_trig = 0, stall = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rd_valid, rd_ready, rd_byte, rd_rsp_valid, wr_valid, wr_ready, wr_byte;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, sm, dm, tm;
    logic [15:0] rd_addr, rd_rsp_data, wr_addr, wr_data, s, d, ea, st;
    logic [10:0] c;
    logic sz, dum, rl, rs;
    int fail_count = 0, checked = 0;
    logic [1:0] exp_b[$];
    dmcc_rexp_t exp_r[$], re;
    dmcc_wexp_t exp_w[$], we;

    always #4 aclk = ~aclk;
    dmcc_channel dmcc_channel_i (.*);
    dmcc_mem_model dmcc_mem_model_i (.aclk, .aresetn, .stall, .rd_valid, .rd_ready, .rd_addr,
        .rd_rsp_valid, .rd_rsp_data, .wr_ready);

    function automatic logic [15:0] memv(input logic [15:0] a);
        return a ^ 16'h5a3c;
    endfunction
    function automatic logic [15:0] step(input logic [15:0] p, input logic [1:0] m, input logic [15:0] t);
        return m == STEP_INC ? p + t : (m == STEP_DEC ? p - t : p);
    endfunction
    task automatic chk(input string n, input logic [31:0] sn, input logic [31:0] e);
        checked++;
        if (sn !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, sn);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [15:0] v, input logic [1:0] r = 2'b00);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'hffff, v};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] v,
        input logic [31:0] m = 32'hffff_ffff, input logic [1:0] r = 2'b00);
        exp_r.push_back('{m, r, v & m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask
    task automatic wq(input logic [15:0] a, input logic [15:0] v, input logic b,
        input logic [15:0] m = 16'hffff);
        exp_w.push_back('{a, v & m, m, b});
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && exp_w.size() != 0; i++) @(posedge aclk);
        chk("pending writes", exp_w.size(), 0);
    endtask

    // Output watcher: responses and writes against the oldest note, rd_byte against the current setup
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            chk("bresp", s_axi_bresp, exp_b.size() ? exp_b.pop_front() : 2'bxx);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            re = exp_r.size() ? exp_r.pop_front() : 'x;
            chk("rresp", s_axi_rresp, re.r);
            chk("rdata", s_axi_rdata & re.m, re.d);
        end
        if (wr_valid && wr_ready) begin
            we = exp_w.size() ? exp_w.pop_front() : 'x;
            chk("wr_addr", wr_addr, we.a);
            chk("wr_data", wr_data & we.m, we.d);
            chk("wr_byte", wr_byte, we.b);
        end
        if (rd_valid && rd_ready) begin
            chk("rd_byte", rd_byte, sz && rd_addr != d && !(sm == STEP_IND && rd_addr == s));
        end
    end

    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(32'h3a67_df78));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFF_CTRL, 0);
        axr(OFF_SRC, 0);
        axr(OFF_CNT, 0);
        axr(OFF_STAT, 0);
        axr(8'h14, 0, 32'hffff_ffff, RESP_SLVERR);
        axw(8'h20, 16'hffff, RESP_SLVERR);
        // Channel off: request stays pending, nothing moves
        axw(OFF_CNT, 16'h0001);
        axw(OFF_CTRL, 16'hfffe);
        axr(OFF_CTRL, 32'h0000_07fe);
        axw(OFF_CTRL, 16'h0000);
        // Single elements over every step code, size and dummy setting
        for (int k = 0; k < 32; k++) begin
            sm = k[4:3];
            dm = k[2:1];
            sz = k[0];
            dum = (sm != STEP_IND) && dm[1];
            tm = {1'b0, dm[0]};
            st = sz ? 16'h0001 : 16'h0002;
            s = 16'h1000 | (16'($urandom) & 16'h0ff0);
            d = 16'h8000 | (16'($urandom) & 16'h0ff0);
            axw(OFF_SRC, s);
            axw(OFF_DST, d);
            axw(OFF_CNT, 16'h0002);
            ea = (sm == STEP_IND) ? memv(s) : s;
            wq((dm == STEP_IND) ? memv(d) : d, memv(ea), sz, sz ? 16'h00ff : 16'hffff);
            if (dum) wq(s, 16'h0000, sz, 16'h0000);
            c = {dum, 1'b0, 1'b1, sm, dm, tm, sz, 1'b1};
            axw(OFF_CTRL, {5'h00, c});
            drain();
            axr(OFF_SRC, step(s, sm, st));
            axr(OFF_DST, step(d, dm, st));
            axr(OFF_CNT, 1);
            axr(OFF_CTRL, c & 11'h6ff);
        end
        // Blocks: reload, repeated continuous, and no reload
        sz = 1'b0;
        for (int k = 0; k < 3; k++) begin
            rl = (k == 0);
            tm = (k == 1) ? 2'b11 : 2'b10;
            rs = rl | tm[0];
            s = 16'h2000 | (16'($urandom) & 16'h0ff0);
            d = 16'h9000 | (16'($urandom) & 16'h0ff0);
            axw(OFF_SRC, s);
            axw(OFF_DST, d);
            axw(OFF_CNT, 16'h0003);
            c = {1'b0, rl, 1'b1, STEP_INC, STEP_INC, tm, 1'b0, 1'b1};
            for (int r = 0; r < 2; r++) begin
                if (r == 0 || rs)
                    for (int i = 0; i < 3; i++) wq(d + 16'(2 * i), memv(s + 16'(2 * i)), 1'b0);
                axw(OFF_CTRL, {5'h00, c});
                drain();
                axr(OFF_CTRL, (r == 0 || rs) ? (c & 11'h6fe) | tm[0] : c);
                axr(OFF_STAT, {rs, 1'b0}, 32'h0000_0002);
                axr(OFF_SRC, s + 16'h0006);
                axr(OFF_CNT, 0);
            end
            axw(OFF_CTRL, 16'h0000);
        end
        // Peripheral trigger starts a one-shot element
        axw(OFF_SRC, 16'h3000);
        axw(OFF_DST, 16'ha000);
        axw(OFF_CNT, 16'h0001);
        axw(OFF_CTRL, 16'h0001);
        wq(16'ha000, memv(16'h3000), 1'b0);
        periph_trig <= 1'b1;
        @(posedge aclk);
        periph_trig <= 1'b0;
        drain();
        axr(OFF_CTRL, 0);
        // Stalled write side fills the FIFO, then drains
        stall <= 1'b1;
        axw(OFF_CNT, 16'h0028);
        for (int i = 0; i < 40; i++) wq(16'hb000 + 16'(2 * i), memv(16'h3000), 1'b0);
        axw(OFF_SRC, 16'h3000);
        axw(OFF_DST, 16'hb000);
        axw(OFF_CTRL, 16'h0119);
        repeat (800) @(posedge aclk);
        axr(OFF_STAT, 32'h0000_2001, 32'h0000_3f01);
        stall <= 1'b0;
        drain();
        axr(OFF_STAT, 0, 32'h0000_3f01);
        results();
    end
endmodule
